// File: src/ccv_capcomp.sv
// Summary of operation
// - Mode 0 output follows software output bit.
// - Selected capture level readable in control word.
// - Channel enable and global enable gate requests.
// - Modes 1,4,5: match sets, toggles, resets.
// - Modes 2,3: match toggles/sets, period resets.
// - Modes 6,7: match toggles/resets, period sets.
// - Non-zero modes update output on clock edge.
// - Match latches selected level into status bit.
// - Edge field: off, rising, falling, both.
// - Channel 0 flag has own top request.
// - Other flags and overflow share one request.
// - Channel 0 flag sets on counter match.
// - Vector codes: 2, 4, overflow 10.
// - Vector reads zero when nothing pending.
// - Vector access clears only the top flag.
// - Remaining flags keep shared request asserted.
// - Vector write stores nothing, clears like read.
`timescale 1ns/1ps
`default_nettype none
module ccv_capcomp #(
    parameter int NUM_CH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Counter core
    input wire logic [15:0] timer_value,
    input wire logic timer_count_en,
    input wire logic timer_overflow,
    // Capture inputs
    input wire logic [NUM_CH-1:0] input_a,
    input wire logic [NUM_CH-1:0] input_b,
    // Processor side
    input wire logic global_irq_enable,
    input wire logic chan0_irq_ack,
    // Outputs
    output logic [NUM_CH-1:0] channel_output,
    output logic chan0_irq,
    output logic shared_irq
);
    typedef struct packed {
        logic ovf_flag;
        logic ovf_ie;
        logic [15:0] rdata;
    } ccv_top_state_type;

    ccv_top_state_type s_r;
    ccv_top_state_type s_nxt;

    logic [15:0] ctl_w [NUM_CH];
    logic [15:0] cmp_w [NUM_CH];
    logic [NUM_CH-1:0] flag_w;
    logic [NUM_CH-1:0] ie_w;
    logic [NUM_CH-1:0] match_w;
    logic [NUM_CH-1:0] vec_clr_w;
    logic [NUM_CH-1:0] pend_w;
    logic ovf_pend;
    logic ovf_clr;
    logic vec_hit;
    logic [15:0] vec_code;
    int ctl_slot;
    int cmp_slot;

    ccv_chan_if ch_if [NUM_CH] ();

    // Slot of a word in a per-channel register bank, -1 when outside
    function automatic int reg_slot(input logic [15:0] a, input logic [15:0] base);
        int off;
        off = int'(a) - int'(base);
        if (off >= 0 && off < 2 * NUM_CH && !a[0]) begin
            return off / 2;
        end
        return -1;
    endfunction

    // Priority code: channel 1 highest, overflow lowest
    function automatic logic [15:0] vec_pick(input logic [NUM_CH-1:0] p, input logic ovf);
        logic [15:0] code;
        code = ccv_pkg::VEC_NONE;
        if (ovf) begin
            code = ccv_pkg::VEC_OVERFLOW;
        end
        for (int k = NUM_CH - 1; k >= 1; k--) begin
            if (p[k]) begin
                code = 16'(2 * k);
            end
        end
        return code;
    endfunction

    // Channel instances, each behind its own interface
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_if[g].wr_ctl = reg_wr && (ctl_slot == g);
        assign ch_if[g].wr_cmp = reg_wr && (cmp_slot == g);
        assign ch_if[g].vec_clr = vec_clr_w[g];
        assign ch_if[g].ack = (g == 0) ? chan0_irq_ack : 1'b0;
        assign ch_if[g].count_en = timer_count_en;
        assign ch_if[g].period_match = match_w[0];
        assign ch_if[g].wdata = reg_wdata;
        assign ch_if[g].timer_value = timer_value;
        assign ctl_w[g] = ch_if[g].ctl_word;
        assign cmp_w[g] = ch_if[g].cmp_val;
        assign flag_w[g] = ch_if[g].flag;
        assign ie_w[g] = ch_if[g].ie;
        assign match_w[g] = ch_if[g].match;
        assign channel_output[g] = ch_if[g].out;
        ccv_channel u_ch (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(ch_if[g].chan),
            .input_a(input_a[g]),
            .input_b(input_b[g])
        );
    end

    // Decode, vector priority and vector clears
    always_comb begin
        ctl_slot = reg_slot(reg_addr, ccv_pkg::ADDR_CTL_BASE);
        cmp_slot = reg_slot(reg_addr, ccv_pkg::ADDR_CMP_BASE);
        // Enabled flags only, so a masked source never steals the vector
        pend_w = flag_w & ie_w;
        pend_w[0] = 1'b0;
        ovf_pend = s_r.ovf_flag & s_r.ovf_ie;
        vec_code = vec_pick(pend_w, ovf_pend);
        // Reads and writes both count as a vector access
        vec_hit = (reg_rd || reg_wr) && (reg_addr == ccv_pkg::ADDR_VECTOR);
        vec_clr_w = '0;
        for (int k = 1; k < NUM_CH; k++) begin
            vec_clr_w[k] = vec_hit && (vec_code == 16'(2 * k));
        end
        ovf_clr = vec_hit && (vec_code == ccv_pkg::VEC_OVERFLOW);
    end

    // Timer control word and registered read data
    always_comb begin
        s_nxt = s_r;
        if (reg_wr && reg_addr == ccv_pkg::ADDR_TIMER_CTL) begin
            s_nxt.ovf_flag = reg_wdata[ccv_pkg::TCTL_OVF_FLAG];
            s_nxt.ovf_ie = reg_wdata[ccv_pkg::TCTL_OVF_IE];
        end
        if (ovf_clr) begin
            s_nxt.ovf_flag = 1'b0;
        end
        // Overflow event beats a clear in the same cycle
        if (timer_overflow) begin
            s_nxt.ovf_flag = 1'b1;
        end
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == ccv_pkg::ADDR_TIMER_CTL) begin
                s_nxt.rdata[ccv_pkg::TCTL_OVF_FLAG] = s_r.ovf_flag;
                s_nxt.rdata[ccv_pkg::TCTL_OVF_IE] = s_r.ovf_ie;
            end else if (reg_addr == ccv_pkg::ADDR_VECTOR) begin
                s_nxt.rdata = vec_code;
            end else if (ctl_slot >= 0) begin
                s_nxt.rdata = ctl_w[ctl_slot];
            end else if (cmp_slot >= 0) begin
                s_nxt.rdata = cmp_w[cmp_slot];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Requests; global enable gates both, as the processor would
    assign chan0_irq = flag_w[0] & ie_w[0] & global_irq_enable;
    assign shared_irq = ((|pend_w) | ovf_pend) & global_irq_enable;
    assign reg_rdata = s_r.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_mode0_follow;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b000)
            |-> (channel_output[1] == ctl_w[1][ccv_pkg::CTL_OUTBIT]);
    endproperty
    a_mode0_follow: assert property (p_mode0_follow) else $error("mode 0 output differs");

    property p_level_view;
        (ctl_w[NUM_CH-1][ccv_pkg::CTL_INSEL_LO +: 2] == 2'b01)
            |-> (ctl_w[NUM_CH-1][ccv_pkg::CTL_LEVEL] == input_b[NUM_CH-1]);
    endproperty
    a_level_view: assert property (p_level_view) else $error("level bit not input B");

    property p_irq_gate;
        chan0_irq == (flag_w[0] && ie_w[0] && global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("channel 0 request gating");

    property p_mode1_set;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b001 && match_w[1] && !reg_wr)
            |=> channel_output[1];
    endproperty
    a_mode1_set: assert property (p_mode1_set) else $error("mode 1 match did not set");

    property p_mode4_toggle;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b100 && match_w[1] && !reg_wr)
            |=> (channel_output[1] != $past(channel_output[1]));
    endproperty
    a_mode4_toggle: assert property (p_mode4_toggle) else $error("mode 4 no toggle");

    property p_mode3_period;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b011 && match_w[0] && !match_w[1] && !reg_wr)
            |=> !channel_output[1];
    endproperty
    a_mode3_period: assert property (p_mode3_period) else $error("mode 3 period no reset");

    property p_mode6_period;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b110 && match_w[0] && !match_w[1] && !reg_wr)
            |=> channel_output[1];
    endproperty
    a_mode6_period: assert property (p_mode6_period) else $error("mode 6 period no set");

    property p_hold_out;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] != 3'b000 && !match_w[1] && !match_w[0] && !reg_wr)
            |=> $stable(channel_output[1]);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output moved without event");

    property p_latch_level;
        (match_w[1] && !reg_wr) |=> (ctl_w[1][ccv_pkg::CTL_LATCHED] == $past(ctl_w[1][ccv_pkg::CTL_LEVEL]));
    endproperty
    a_latch_level: assert property (p_latch_level) else $error("match did not latch level");

    property p_ch0_flag;
        match_w[0] |=> flag_w[0];
    endproperty
    a_ch0_flag: assert property (p_ch0_flag) else $error("channel 0 flag not set");

    property p_vec_ch1;
        (reg_rd && reg_addr == ccv_pkg::ADDR_VECTOR && pend_w[1]) |=> (reg_rdata == 16'h0002);
    endproperty
    a_vec_ch1: assert property (p_vec_ch1) else $error("vector not 2");

    property p_vec_empty;
        (reg_rd && reg_addr == ccv_pkg::ADDR_VECTOR && !(|pend_w) && !ovf_pend)
            |=> (reg_rdata == 16'h0000);
    endproperty
    a_vec_empty: assert property (p_vec_empty) else $error("empty vector not zero");

    property p_vec_clear_one;
        (reg_rd && reg_addr == ccv_pkg::ADDR_VECTOR && pend_w[1] && pend_w[2] && !match_w[1])
            |=> (!flag_w[1] && flag_w[2]);
    endproperty
    a_vec_clear_one: assert property (p_vec_clear_one) else $error("wrong flag cleared");

    property p_vec_keep_irq;
        (reg_rd && reg_addr == ccv_pkg::ADDR_VECTOR && pend_w[1] && pend_w[2] && global_irq_enable)
            ##1 global_irq_enable |-> shared_irq;
    endproperty
    a_vec_keep_irq: assert property (p_vec_keep_irq) else $error("shared request dropped");

    property p_vec_write;
        (reg_wr && reg_addr == ccv_pkg::ADDR_VECTOR && ovf_pend && !(|pend_w) && !timer_overflow)
            |=> !s_r.ovf_flag;
    endproperty
    a_vec_write: assert property (p_vec_write) else $error("write did not clear");

    property p_cov_mode4;
        (ctl_w[1][ccv_pkg::CTL_MODE_LO +: 3] == 3'b100 && match_w[1]);
    endproperty
    c_cov_mode4: cover property (p_cov_mode4);

    property p_cov_two_pending;
        (vec_hit && pend_w[1] && pend_w[2]);
    endproperty
    c_cov_two_pending: cover property (p_cov_two_pending);

    property p_cov_capture;
        (ctl_w[NUM_CH-1][ccv_pkg::CTL_CAPSEL] && ctl_w[NUM_CH-1][ccv_pkg::CTL_FLAG]
            && ctl_w[NUM_CH-1][ccv_pkg::CTL_OVR]);
    endproperty
    c_cov_capture: cover property (p_cov_capture);
endmodule // ccv_capcomp
`default_nettype wire

// File: src/ccv_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccv_chan_if;
    logic wr_ctl;
    logic wr_cmp;
    logic vec_clr;
    logic ack;
    logic count_en;
    logic period_match;
    logic [15:0] wdata;
    logic [15:0] timer_value;
    logic [15:0] ctl_word;
    logic [15:0] cmp_val;
    logic flag;
    logic ie;
    logic match;
    logic out;
    modport ctrl(output wr_ctl, wr_cmp, vec_clr, ack, count_en, period_match, wdata,
                 timer_value, input ctl_word, cmp_val, flag, ie, match, out);
    modport chan(input wr_ctl, wr_cmp, vec_clr, ack, count_en, period_match, wdata,
                 timer_value, output ctl_word, cmp_val, flag, ie, match, out);
endinterface
`default_nettype wire

// File: src/ccv_channel.sv
`timescale 1ns/1ps
`default_nettype none
module ccv_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link to the register side
    ccv_chan_if.chan bus,
    // Capture inputs
    input wire logic input_a,
    input wire logic input_b
);
    typedef struct packed {
        logic [1:0] edge_mode;
        logic [1:0] insel;
        logic sync_sel;
        logic latched;
        logic capsel;
        logic [2:0] mode;
        logic ie;
        logic outbit;
        logic ovr;
        logic flag;
        logic [15:0] cmp_val;
        logic out_ff;
        logic sync;
        logic prev;
    } ccv_chan_state_type;

    ccv_chan_state_type s_r;
    ccv_chan_state_type s_nxt;
    logic level;
    logic edge_src;
    logic rise;
    logic fall;
    logic capture;

    // Next output flop value per mode, both matches seen together
    function automatic logic next_out(input logic [2:0] m, input logic eq0, input logic eqx,
                                      input logic cur);
        logic d;
        d = cur;
        unique case (ccv_pkg::ccv_outmode_type'(m))
            ccv_pkg::OM_OUT: d = cur;
            ccv_pkg::OM_SET: d = eqx ? 1'b1 : cur;
            ccv_pkg::OM_TOG_RST: d = eqx ? (eq0 ? 1'b1 : ~cur) : (eq0 ? 1'b0 : cur);
            ccv_pkg::OM_SET_RST: d = eqx ? 1'b1 : (eq0 ? 1'b0 : cur);
            ccv_pkg::OM_TOG: d = eqx ? ~cur : cur;
            ccv_pkg::OM_RST: d = eqx ? 1'b0 : cur;
            ccv_pkg::OM_TOG_SET: d = eqx ? (eq0 ? 1'b0 : ~cur) : (eq0 ? 1'b1 : cur);
            ccv_pkg::OM_RST_SET: d = eqx ? 1'b0 : (eq0 ? 1'b1 : cur);
        endcase
        return d;
    endfunction

    // Source select, edge detect and compare
    always_comb begin
        unique case (ccv_pkg::ccv_insel_type'(s_r.insel))
            ccv_pkg::IN_A: level = input_a;
            ccv_pkg::IN_B: level = input_b;
            ccv_pkg::IN_GND: level = 1'b0;
            ccv_pkg::IN_VCC: level = 1'b1;
        endcase
        edge_src = s_r.sync_sel ? s_r.sync : level;
        rise = edge_src & ~s_r.prev;
        fall = ~edge_src & s_r.prev;
        capture = s_r.capsel & ((s_r.edge_mode[0] & rise) | (s_r.edge_mode[1] & fall));
        bus.match = bus.count_en & ~s_r.capsel & (bus.timer_value == s_r.cmp_val);
    end

    // Next state; hardware sets win over software clears
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync = level;
        s_nxt.prev = edge_src;
        if (bus.wr_ctl) begin
            s_nxt.edge_mode = bus.wdata[ccv_pkg::CTL_EDGE_LO +: 2];
            s_nxt.insel = bus.wdata[ccv_pkg::CTL_INSEL_LO +: 2];
            s_nxt.sync_sel = bus.wdata[ccv_pkg::CTL_SYNC];
            s_nxt.capsel = bus.wdata[ccv_pkg::CTL_CAPSEL];
            s_nxt.mode = bus.wdata[ccv_pkg::CTL_MODE_LO +: 3];
            s_nxt.ie = bus.wdata[ccv_pkg::CTL_IE];
            s_nxt.outbit = bus.wdata[ccv_pkg::CTL_OUTBIT];
            s_nxt.ovr = bus.wdata[ccv_pkg::CTL_OVR];
            s_nxt.flag = bus.wdata[ccv_pkg::CTL_FLAG];
        end
        if (bus.wr_cmp) begin
            s_nxt.cmp_val = bus.wdata;
        end
        if (bus.vec_clr || bus.ack) begin
            s_nxt.flag = 1'b0;
        end
        if (bus.match) begin
            s_nxt.latched = level;
            s_nxt.flag = 1'b1;
        end
        if (capture) begin
            s_nxt.cmp_val = bus.timer_value;
            // Only a real overrun sets it, so a software clear in this cycle survives
            if (s_r.flag) begin
                s_nxt.ovr = 1'b1;
            end
            s_nxt.flag = 1'b1;
        end
        // Mode 0 keeps the flop tracking so a mode change starts clean
        if (s_r.mode == 3'b000) begin
            s_nxt.out_ff = s_nxt.outbit;
        end else begin
            s_nxt.out_ff = next_out(s_r.mode, bus.period_match, bus.match, s_r.out_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Read view of the channel
    always_comb begin
        bus.ctl_word = ccv_pkg::CTL_RESET;
        bus.ctl_word[ccv_pkg::CTL_EDGE_LO +: 2] = s_r.edge_mode;
        bus.ctl_word[ccv_pkg::CTL_INSEL_LO +: 2] = s_r.insel;
        bus.ctl_word[ccv_pkg::CTL_SYNC] = s_r.sync_sel;
        bus.ctl_word[ccv_pkg::CTL_LATCHED] = s_r.latched;
        bus.ctl_word[ccv_pkg::CTL_CAPSEL] = s_r.capsel;
        bus.ctl_word[ccv_pkg::CTL_MODE_LO +: 3] = s_r.mode;
        bus.ctl_word[ccv_pkg::CTL_IE] = s_r.ie;
        bus.ctl_word[ccv_pkg::CTL_LEVEL] = level;
        bus.ctl_word[ccv_pkg::CTL_OUTBIT] = s_r.outbit;
        bus.ctl_word[ccv_pkg::CTL_OVR] = s_r.ovr;
        bus.ctl_word[ccv_pkg::CTL_FLAG] = s_r.flag;
    end
    assign bus.cmp_val = s_r.cmp_val;
    assign bus.flag = s_r.flag;
    assign bus.ie = s_r.ie;
    assign bus.out = (s_r.mode == 3'b000) ? s_r.outbit : s_r.out_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_capture_edge;
        (s_r.capsel && s_r.edge_mode == 2'b01 && rise) |=> s_r.flag;
    endproperty
    a_capture_edge: assert property (p_capture_edge) else $error("rising capture lost");

    property p_capture_ovr;
        (capture && s_r.flag) |=> s_r.ovr;
    endproperty
    a_capture_ovr: assert property (p_capture_ovr) else $error("overflow not set");
endmodule // ccv_channel
`default_nettype wire

// File: src/ccv_pkg.sv
package ccv_pkg;
    // Register map: one 16-bit word per register, word aligned
    localparam logic [15:0] ADDR_TIMER_CTL = 16'h0160;
    localparam logic [15:0] ADDR_CTL_BASE = 16'h0162;
    localparam logic [15:0] ADDR_CMP_BASE = 16'h0172;
    localparam logic [15:0] ADDR_VECTOR = 16'h0180;
    // Channel control word fields
    localparam int CTL_FLAG = 0;
    localparam int CTL_OVR = 1;
    localparam int CTL_OUTBIT = 2;
    localparam int CTL_LEVEL = 3;
    localparam int CTL_IE = 4;
    localparam int CTL_MODE_LO = 5;
    localparam int CTL_CAPSEL = 8;
    localparam int CTL_LATCHED = 10;
    localparam int CTL_SYNC = 11;
    localparam int CTL_INSEL_LO = 12;
    localparam int CTL_EDGE_LO = 14;
    // Timer control word fields
    localparam int TCTL_OVF_FLAG = 0;
    localparam int TCTL_OVF_IE = 1;
    // Reset values
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    // Shared vector codes
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam logic [15:0] VEC_OVERFLOW = 16'h000a;
    // Output modes
    typedef enum logic [2:0] {
        OM_OUT = 3'b000,
        OM_SET = 3'b001,
        OM_TOG_RST = 3'b010,
        OM_SET_RST = 3'b011,
        OM_TOG = 3'b100,
        OM_RST = 3'b101,
        OM_TOG_SET = 3'b110,
        OM_RST_SET = 3'b111
    } ccv_outmode_type;
    // Capture input sources
    typedef enum logic [1:0] {
        IN_A = 2'b00,
        IN_B = 2'b01,
        IN_GND = 2'b10,
        IN_VCC = 2'b11
    } ccv_insel_type;
endpackage

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int NCH = 3;
    localparam logic [15:0] CTL0 = ccv_pkg::ADDR_CTL_BASE;
    localparam logic [15:0] CTL1 = ccv_pkg::ADDR_CTL_BASE + 16'h0002;
    localparam logic [15:0] CTL2 = ccv_pkg::ADDR_CTL_BASE + 16'h0004;
    localparam logic [15:0] CMP1 = ccv_pkg::ADDR_CMP_BASE + 16'h0002;
    localparam logic [15:0] CMP2 = ccv_pkg::ADDR_CMP_BASE + 16'h0004;
    localparam logic [15:0] VEC = ccv_pkg::ADDR_VECTOR;
    // Bench-driven inputs, all defined at time zero
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [15:0] timer_value = 16'h0001;
    logic timer_count_en = 1'h0;
    logic timer_overflow = 1'h0;
    logic [NCH-1:0] input_a = 3'h0;
    logic [NCH-1:0] input_b = 3'h0;
    logic global_irq_enable = 1'h1;
    logic chan0_irq_ack = 1'h0;
    // Observed outputs and bench state
    logic [15:0] reg_rdata;
    logic [NCH-1:0] channel_output;
    logic chan0_irq;
    logic shared_irq;
    int error_cnt = 0;
    int compares = 0;
    logic [15:0] d, tv, c0, c1, cfg, ex;
    logic s, a, hit, cm;
    logic [15:0] codes [4] = '{16'h0002, 16'h0004, ccv_pkg::VEC_OVERFLOW, ccv_pkg::VEC_NONE};

    ccv_capcomp #(.NUM_CH(NCH)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_value(timer_value), .timer_count_en(timer_count_en),
        .timer_overflow(timer_overflow), .input_a(input_a), .input_b(input_b),
        .global_irq_enable(global_irq_enable), .chan0_irq_ack(chan0_irq_ack),
        .channel_output(channel_output), .chan0_irq(chan0_irq), .shared_irq(shared_irq));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [15:0] wd);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] ad, output logic [15:0] rv);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        rv = reg_rdata;
    endtask

    // One counted cycle at value v, then settle
    task automatic evt(input logic [15:0] v);
        @(posedge clk);
        timer_value <= v;
        timer_count_en <= 1'h1;
        @(posedge clk);
        timer_count_en <= 1'h0;
        @(posedge clk);
        #1;
    endtask

    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Expected output flop after one event
    function automatic logic f_out(int m, logic cur, logic cm, logic pm);
        case (m)
            1: return cm | cur;
            2: return pm ? cm : cur ^ cm;
            3: return cm | (cur & ~pm);
            4: return cur ^ cm;
            5: return cur & ~cm;
            6: return pm ? ~cm : cur ^ cm;
            7: return ~cm & (cur | pm);
            default: return cur;
        endcase
    endfunction

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    initial begin
        void'($urandom(32'hd288c95c));
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        // Whole map reads zero after reset, holes included
        for (int ad = 16'h0160; ad <= 16'h0180; ad += 2) begin
            rd(16'(ad), d);
            chk(d, 16'h0000);
        end
        chk(16'(channel_output), 16'h0000);
        wr(CTL2, 16'h0608);
        rd(CTL2, d);
        chk(d & 16'h0608, 16'h0000);
        // Output modes; ranges keep the two compare values apart
        c0 = 16'h1000 | 16'($urandom_range(255));
        c1 = 16'h2000 | 16'($urandom_range(255));
        wr(ccv_pkg::ADDR_CMP_BASE, c0);
        wr(CMP1, c1);
        for (int m = 1; m < 8; m++) begin
            s = 1'($urandom_range(1));
            wr(CTL1, 16'(s) << 2);
            @(posedge clk);
            #1;
            chk(16'(channel_output[1]), 16'(s));
            wr(CTL1, (16'(m) << 5) | (16'(s) << 2));
            repeat (4) begin
                cm = 1'($urandom_range(1));
                evt(cm ? c1 : c0);
                s = f_out(m, s, cm, ~cm);
                chk(16'(channel_output[1]), 16'(s));
            end
        end
        // Channel 0 request, its gate and its acknowledge
        wr(CTL0, 16'h0010);
        evt(c0);
        chk(16'(chan0_irq), 16'h0001);
        @(posedge clk) global_irq_enable <= 1'h0;
        @(posedge clk);
        #1;
        chk(16'(chan0_irq), 16'h0000);
        @(posedge clk) global_irq_enable <= 1'h1;
        @(posedge clk) chan0_irq_ack <= 1'h1;
        @(posedge clk) chan0_irq_ack <= 1'h0;
        @(posedge clk);
        #1;
        chk(16'(chan0_irq), 16'h0000);
        // Match latches the level; it holds while the pin moves
        wr(CTL1, 16'h0000);
        repeat (4) begin
            a = 1'($urandom_range(1));
            c1 = c1 + 16'h0010;
            wr(CMP1, c1);
            @(posedge clk) input_a[1] <= a;
            evt(c1);
            @(posedge clk) input_a[1] <= ~a;
            rd(CTL1, d);
            chk(16'(d[10]), 16'(a));
            chk(16'(d[3]), 16'(!a));
        end
        // Every input source, capture edges off
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            input_a[2] <= 1'($urandom_range(1));
            input_b[2] <= 1'($urandom_range(1));
            wr(CTL2, 16'h0100 | (16'(i) << 12));
            ex = (i == 0) ? 16'(input_a[2]) : (i == 1) ? 16'(input_b[2]) : 16'(i == 3);
            rd(CTL2, d);
            chk(16'(d[3]), ex);
        end
        // Each edge mode against both directions, sync chosen at random
        for (int e = 0; e < 4; e++) begin
            for (int dir = 0; dir < 2; dir++) begin
                @(posedge clk) input_a[2] <= 1'(dir);
                cfg = (16'(e) << 14) | (16'($urandom_range(1)) << 11) | 16'h0100;
                wr(CTL2, cfg);
                // Source switch may itself capture; let it land before clearing
                repeat (3) @(posedge clk);
                wr(CMP2, 16'h0000);
                wr(CTL2, cfg);
                tv = 16'($urandom_range(65535));
                @(posedge clk);
                timer_value <= tv;
                input_a[2] <= 1'(dir == 0);
                repeat (4) @(posedge clk);
                hit = (e == 3) || (e == 1 && dir == 0) || (e == 2 && dir == 1);
                rd(CMP2, d);
                chk(d, hit ? tv : 16'h0000);
                rd(CTL2, d);
                chk(16'(d[0]), 16'(hit));
            end
        end
        // Second capture over a pending flag
        @(posedge clk) input_a[2] <= 1'h1;
        repeat (4) @(posedge clk);
        rd(CTL2, d);
        chk(d & 16'h0003, 16'h0003);
        rd(CMP2, d);
        chk(d, tv);
        rd(CTL2, d);
        chk(16'(d[1]), 16'h0001);
        // Shared vector: priority order, one flag per access
        wr(CTL1, 16'h0011);
        wr(CTL2, 16'h0011);
        wr(ccv_pkg::ADDR_TIMER_CTL, 16'h0002);
        @(posedge clk) timer_overflow <= 1'h1;
        @(posedge clk) timer_overflow <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1;
            chk(16'(shared_irq), 16'(codes[k] != 16'h0000));
            rd(VEC, d);
            chk(d, codes[k]);
        end
        // A write discards the top event like a read
        wr(CTL1, 16'h0011);
        wr(CTL2, 16'h0011);
        wr(VEC, 16'hffff);
        rd(VEC, d);
        chk(d, 16'h0004);
        // Overflow alone pending; a write must drop it too
        wr(ccv_pkg::ADDR_TIMER_CTL, 16'h0003);
        wr(VEC, 16'h0000);
        rd(ccv_pkg::ADDR_TIMER_CTL, d);
        chk(d, 16'h0002);
        // Masked flag neither requests nor shows in the vector
        wr(CTL1, 16'h0001);
        @(posedge clk);
        #1;
        chk(16'(shared_irq), 16'h0000);
        rd(VEC, d);
        chk(d, ccv_pkg::VEC_NONE);
        wr(CTL1, 16'h0011);
        #1 chk(16'(shared_irq), 16'h0001);
        @(posedge clk) global_irq_enable <= 1'h0;
        @(posedge clk);
        #1;
        chk(16'(shared_irq), 16'h0000);
        test_done();
    end
endmodule // testbench
`default_nettype wire
